// >>> hdl/ebr_pkg.sv
// Shared constants, width modes and address arithmetic for the embedded RAM block
package ebr_pkg;

  // Storage geometry
  localparam int DATA_W       = 36;
  localparam int ADDR_W       = 12;
  localparam int BE_W         = 4;
  localparam int LANE_BITS    = 9;
  localparam int BYTE_BITS    = 8;
  localparam int DEPTH_LANES  = 512;
  localparam int CAPACITY     = 4608;
  localparam int BYTE_EN_MINW = 16;

  // Reset values
  localparam logic [DATA_W-1:0] RDATA_RST = 36'h0_0000_0000;
  localparam logic [BE_W-1:0]   BE_RST    = 4'h0;

  // Port width modes
  typedef enum logic [3:0] {
    EBR_W1, EBR_W2, EBR_W4, EBR_W8, EBR_W16, EBR_W32,
    EBR_W9, EBR_W18, EBR_W36
  } ebr_width_e;

  // Data bits carried by a width mode
  function automatic int width_bits(input ebr_width_e w);
    case (w)
      EBR_W1:  width_bits = 1;
      EBR_W2:  width_bits = 2;
      EBR_W4:  width_bits = 4;
      EBR_W8:  width_bits = 8;
      EBR_W16: width_bits = 16;
      EBR_W32: width_bits = 32;
      EBR_W9:  width_bits = 9;
      EBR_W18: width_bits = 18;
      EBR_W36: width_bits = 36;
      default: width_bits = 1;
    endcase
  endfunction

  // Widths with a ninth parity bit per lane
  function automatic logic is_parity(input ebr_width_e w);
    is_parity = (w == EBR_W9) || (w == EBR_W18) || (w == EBR_W36);
  endfunction

  // Physical bit position of data bit k at word address a
  function automatic int phys_bit(input ebr_width_e w, input logic [ADDR_W-1:0] a, input int k);
    int l;
    l = int'(a) * width_bits(w) + k;
    if (is_parity(w))
      phys_bit = l % CAPACITY;
    else
      phys_bit = ((l / BYTE_BITS) * LANE_BITS + (l % BYTE_BITS)) % CAPACITY;
  endfunction

endpackage

// >>> hdl/ebr_port_regs.sv
// Input-side registers of one RAM port
`timescale 1ns/100ps
module ebr_port_regs (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Raw port controls
  input  wire logic                        i_ce,
  input  wire logic                        i_we,
  input  wire logic [ebr_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [ebr_pkg::DATA_W-1:0]  i_wdata,
  input  wire logic [ebr_pkg::BE_W-1:0]    i_be,
  // Registered controls
  output logic                             o_we,
  output logic      [ebr_pkg::ADDR_W-1:0]  o_addr,
  output logic      [ebr_pkg::DATA_W-1:0]  o_wdata,
  output logic      [ebr_pkg::BE_W-1:0]    o_be
);

  logic                       next_we;
  logic [ebr_pkg::ADDR_W-1:0] next_addr;
  logic [ebr_pkg::DATA_W-1:0] next_wdata;
  logic [ebr_pkg::BE_W-1:0]   next_be;

  // Capture on clock enable; write strobe lasts one cycle
  always_comb begin
    next_we    = i_ce & i_we;
    next_addr  = i_ce ? i_addr : o_addr;
    next_wdata = i_ce ? i_wdata : o_wdata;
    next_be    = i_ce ? i_be : o_be;
  end

  // Always-present input registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_we    <= 1'b0;
      o_addr  <= '0;
      o_wdata <= ebr_pkg::RDATA_RST;
      o_be    <= ebr_pkg::BE_RST;
    end else begin
      o_we    <= next_we;
      o_addr  <= next_addr;
      o_wdata <= next_wdata;
      o_be    <= next_be;
    end
  end

endmodule // ebr_port_regs

// >>> hdl/ebr_ram.sv
// Two-port embedded RAM block with mixed widths and byte-lane write masking
// Contract
// - Byte-lane masking exists only for 16, 18, 32 and 36 bit write widths.
// - A masked-off lane keeps its stored bits while enabled lanes take new data.
// - In parity widths each enable covers nine bits, enables 2 and 3 only in the 36-bit width.
// - In 16 and 32 bit widths the enables cover eight-bit lanes in the same order.
// - Any combination of lane enables is honoured lane by lane.
// - Total storage is 4,608 bits, which bounds any shift-register use.
// - The output register of each port may be clocked by either port's clock enable.
// - Address, data, byte enables and write enable are always registered; only output may bypass.
// - Simple dual-port pairs any widths within the byte group or within the parity group.
// - True dual-port pairs within a group but excludes 32 and 36 bit widths.
`timescale 1ns/100ps
module ebr_ram (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Configuration
  input  wire logic                        i_true_dual,
  input  wire ebr_pkg::ebr_width_e         i_width_a,
  input  wire ebr_pkg::ebr_width_e         i_width_b,
  input  wire logic                        i_outreg_a,
  input  wire logic                        i_outreg_b,
  input  wire logic                        i_outclk_sel_a,
  input  wire logic                        i_outclk_sel_b,
  // Port A
  input  wire logic                        i_ce_a,
  input  wire logic                        i_we_a,
  input  wire logic                        i_clr_a,
  input  wire logic [ebr_pkg::ADDR_W-1:0]  i_addr_a,
  input  wire logic [ebr_pkg::DATA_W-1:0]  i_wdata_a,
  input  wire logic [ebr_pkg::BE_W-1:0]    i_be_a,
  output logic      [ebr_pkg::DATA_W-1:0]  o_rdata_a,
  // Port B
  input  wire logic                        i_ce_b,
  input  wire logic                        i_we_b,
  input  wire logic                        i_clr_b,
  input  wire logic [ebr_pkg::ADDR_W-1:0]  i_addr_b,
  input  wire logic [ebr_pkg::DATA_W-1:0]  i_wdata_b,
  input  wire logic [ebr_pkg::BE_W-1:0]    i_be_b,
  output logic      [ebr_pkg::DATA_W-1:0]  o_rdata_b,
  // Status
  output logic                             o_cfg_err
);

  // Registered port controls
  logic                       we_a, we_b;
  logic [ebr_pkg::ADDR_W-1:0] addr_a, addr_b;
  logic [ebr_pkg::DATA_W-1:0] wdata_a, wdata_b;
  logic [ebr_pkg::BE_W-1:0]   be_a, be_b;

  // Storage, 512 lanes of nine bits
  logic [ebr_pkg::LANE_BITS-1:0] mem      [ebr_pkg::DEPTH_LANES];
  logic [ebr_pkg::LANE_BITS-1:0] next_mem [ebr_pkg::DEPTH_LANES];

  logic [ebr_pkg::DATA_W-1:0] raw_a, raw_b, oreg_a, oreg_b, next_oreg_a, next_oreg_b;
  logic [ebr_pkg::BE_W-1:0]   mask_a, mask_b;
  logic                       cfg_bad, next_cfg_err, wr_a, wr_b;

  // Per-port input registers, own clock enable each
  ebr_port_regs u_regs_a (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce_a),
    .i_we    (i_we_a),
    .i_addr  (i_addr_a),
    .i_wdata (i_wdata_a),
    .i_be    (i_be_a),
    .o_we    (we_a),
    .o_addr  (addr_a),
    .o_wdata (wdata_a),
    .o_be    (be_a)
  );

  ebr_port_regs u_regs_b (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_ce    (i_ce_b),
    .i_we    (i_we_b),
    .i_addr  (i_addr_b),
    .i_wdata (i_wdata_b),
    .i_be    (i_be_b),
    .o_we    (we_b),
    .o_addr  (addr_b),
    .o_wdata (wdata_b),
    .o_be    (be_b)
  );

  // Lane mask: byte enables only in wide widths, all lanes otherwise
  function automatic logic [ebr_pkg::BE_W-1:0] lane_mask(input ebr_pkg::ebr_width_e w,
                                                         input logic [ebr_pkg::BE_W-1:0] be);
    if (ebr_pkg::width_bits(w) < ebr_pkg::BYTE_EN_MINW)
      lane_mask = 4'hf;
    else if (w == ebr_pkg::EBR_W16 || w == ebr_pkg::EBR_W18)
      lane_mask = {2'h0, be[1:0]};
    else
      lane_mask = be;
  endfunction

  // Read a word straight from storage
  function automatic logic [ebr_pkg::DATA_W-1:0] read_word(input ebr_pkg::ebr_width_e w,
                                                           input logic [ebr_pkg::ADDR_W-1:0] a);
    int p;
    read_word = '0;
    for (int k = 0; k < ebr_pkg::DATA_W; k++) begin
      p = ebr_pkg::phys_bit(w, a, k);
      if (k < ebr_pkg::width_bits(w))
        read_word[k] = mem[p / ebr_pkg::LANE_BITS][p % ebr_pkg::LANE_BITS];
    end
  endfunction

  // Legal pairing check
  always_comb begin
    cfg_bad = (ebr_pkg::is_parity(i_width_a) != ebr_pkg::is_parity(i_width_b));
    if (i_true_dual && (i_width_a inside {ebr_pkg::EBR_W32, ebr_pkg::EBR_W36} ||
                        i_width_b inside {ebr_pkg::EBR_W32, ebr_pkg::EBR_W36}))
      cfg_bad = 1'b1;
    next_cfg_err = cfg_bad;
    mask_a = lane_mask(i_width_a, be_a);
    mask_b = lane_mask(i_width_b, be_b);
    wr_a   = we_a & ~cfg_bad;
    wr_b   = we_b & ~cfg_bad & i_true_dual;              // Port B writes only in true dual
  end

  // Storage update; port B lands after port A on a shared bit
  always_comb begin
    int p;
    int lane;
    p    = 0;
    lane = 0;
    for (int i = 0; i < ebr_pkg::DEPTH_LANES; i++)
      next_mem[i] = mem[i];
    for (int k = 0; k < ebr_pkg::DATA_W; k++) begin
      lane = ebr_pkg::is_parity(i_width_a) ? k / ebr_pkg::LANE_BITS : k / ebr_pkg::BYTE_BITS;
      p    = ebr_pkg::phys_bit(i_width_a, addr_a, k);
      if (wr_a && k < ebr_pkg::width_bits(i_width_a) && mask_a[lane])
        next_mem[p / ebr_pkg::LANE_BITS][p % ebr_pkg::LANE_BITS] = wdata_a[k];
    end
    for (int k = 0; k < ebr_pkg::DATA_W; k++) begin
      lane = ebr_pkg::is_parity(i_width_b) ? k / ebr_pkg::LANE_BITS : k / ebr_pkg::BYTE_BITS;
      p    = ebr_pkg::phys_bit(i_width_b, addr_b, k);
      if (wr_b && k < ebr_pkg::width_bits(i_width_b) && mask_b[lane])
        next_mem[p / ebr_pkg::LANE_BITS][p % ebr_pkg::LANE_BITS] = wdata_b[k];
    end
  end

  // Storage registers, 4,608 bits in all
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < ebr_pkg::DEPTH_LANES; i++)
      mem[i] <= next_mem[i];
  end

  // Output registers; either port's clock enable may drive each
  always_comb begin
    raw_a = read_word(i_width_a, addr_a);
    raw_b = read_word(i_width_b, addr_b);
    next_oreg_a = oreg_a;
    next_oreg_b = oreg_b;
    if (i_clr_a)
      next_oreg_a = ebr_pkg::RDATA_RST;
    else if (i_outclk_sel_a ? i_ce_b : i_ce_a)
      next_oreg_a = raw_a;
    if (i_clr_b)
      next_oreg_b = ebr_pkg::RDATA_RST;
    else if (i_outclk_sel_b ? i_ce_b : i_ce_a)
      next_oreg_b = raw_b;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      oreg_a    <= ebr_pkg::RDATA_RST;
      oreg_b    <= ebr_pkg::RDATA_RST;
      o_cfg_err <= 1'b0;
    end else begin
      oreg_a    <= next_oreg_a;
      oreg_b    <= next_oreg_b;
      o_cfg_err <= next_cfg_err;
    end
  end

  // Output register or bypass
  always_comb begin
    o_rdata_a = i_outreg_a ? oreg_a : raw_a;
    o_rdata_b = i_outreg_b ? oreg_b : raw_b;
  end

  // Helper: lane 0 of a port A W18 write, captured before the write
  logic [ebr_pkg::LANE_BITS-1:0] keep_val;
  int                            keep_idx;
  always_ff @(posedge i_clk) begin
    keep_idx <= ebr_pkg::phys_bit(i_width_a, addr_a, 0) / ebr_pkg::LANE_BITS;
    keep_val <= mem[ebr_pkg::phys_bit(i_width_a, addr_a, 0) / ebr_pkg::LANE_BITS];
  end

  chk_lane_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_a && !wr_b && i_width_a == ebr_pkg::EBR_W18 && !be_a[0]) |=> mem[keep_idx] == keep_val)
    else $error("masked lane changed");
  chk_narrow_nomask: assert property (@(posedge i_clk) disable iff (i_rst)
    (ebr_pkg::width_bits(i_width_a) < 16) |-> mask_a == 4'hf)
    else $error("narrow width masked");
  chk_wide_mask: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_width_a == ebr_pkg::EBR_W18) |-> mask_a[3:2] == 2'h0 && mask_a[1:0] == be_a[1:0])
    else $error("x18 lane mask wrong");
  chk_we_gated: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_ce_a || !i_we_a) |=> !we_a)
    else $error("write without enable");
  chk_cross_group: assert property (@(posedge i_clk) disable iff (i_rst)
    (ebr_pkg::is_parity(i_width_a) != ebr_pkg::is_parity(i_width_b)) |-> !wr_a && !wr_b ##1 o_cfg_err)
    else $error("cross-group write");
  chk_tdp_wide: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_true_dual && i_width_b == ebr_pkg::EBR_W36) |-> !wr_b && !wr_a)
    else $error("wide width in true dual");
  chk_clr_out: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_clr_b && i_outreg_b) ##1 i_outreg_b |-> o_rdata_b == '0)
    else $error("clear ignored");
  chk_out_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_clr_a && !(i_outclk_sel_a ? i_ce_b : i_ce_a) && i_outreg_a) ##1 i_outreg_a |-> $stable(oreg_a))
    else $error("output reg moved without enable");
  chk_bypass: assert property (@(posedge i_clk) disable iff (i_rst)
    (!i_outreg_a && !i_ce_a && !wr_a && !wr_b) ##1 (!i_outreg_a && $stable(i_width_a)) |-> $stable(o_rdata_a))
    else $error("bypass output moved");
  chk_addr_reg: assert property (@(posedge i_clk) disable iff (i_rst)
    i_ce_a |=> addr_a == $past(i_addr_a))
    else $error("address not registered");

  cov_masked_write: cover property (@(posedge i_clk) disable iff (i_rst) wr_a && mask_a != 4'hf);
  cov_both_write:   cover property (@(posedge i_clk) disable iff (i_rst) wr_a && wr_b);
  cov_out_clr:      cover property (@(posedge i_clk) disable iff (i_rst) i_clr_a && i_outreg_a);

endmodule // ebr_ram

// >>> test/ebr_user_port.sv
// User-logic model that presents one RAM port's controls
`timescale 1ns/100ps
module ebr_user_port (
  // Clock
  input  wire logic        i_clk,
  // Bench requests
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic        i_clr,
  input  wire logic [11:0] i_addr,
  input  wire logic [35:0] i_wdata,
  input  wire logic [3:0]  i_be,
  // Port controls
  output logic             o_ce,
  output logic             o_we,
  output logic             o_clr,
  output logic      [11:0] o_addr,
  output logic      [35:0] o_wdata,
  output logic      [3:0]  o_be
);
  logic [52:0] junk = '0;
  // Idle fields toggle so a stale value never looks like a request
  always_ff @(posedge i_clk) begin
    junk <= i_req ? ~{i_we, i_addr, i_wdata, i_be} : ~junk;
  end
  // Own enable, write and clear per port; any lane mix passes through
  assign o_ce = i_req;
  assign o_clr = i_clr;
  assign o_we = i_req ? i_we : junk[52];
  assign {o_addr, o_wdata, o_be} = i_req ? {i_addr, i_wdata, i_be} : junk[51:0];
endmodule  // ebr_user_port

// >>> test/ebr_ram_tb_top.sv
// Bench: directed and random traffic on both ports against a bit-level model
`timescale 1ns/100ps
module ebr_ram_tb_top;
  logic                clk, rst, td, ora, orb, sla, slb;
  ebr_pkg::ebr_width_e wa, wb;
  logic                rq[2], we[2], cl[2];
  logic [11:0]         ad[2];
  logic [35:0]         wd[2];
  logic [3:0]          be[2];
  wire                 ce[2], uw[2], uc[2], cerr;
  wire  [11:0]         ua[2];
  wire  [35:0]         ud[2], rd[2];
  wire  [3:0]          ub[2];
  logic                mem[4608];
  int                  n_fail, total_checks;
  integer              seed;
  int                  tbl[9] = '{1, 2, 4, 8, 16, 32, 9, 18, 36};

  // User logic on each port
  for (genvar p = 0; p < 2; p++) begin : g_port
    ebr_user_port ebr_user_port_i (.i_clk(clk), .i_req(rq[p]), .i_we(we[p]), .i_clr(cl[p]), .i_addr(ad[p]),
      .i_wdata(wd[p]), .i_be(be[p]), .o_ce(ce[p]), .o_we(uw[p]), .o_clr(uc[p]), .o_addr(ua[p]),
      .o_wdata(ud[p]), .o_be(ub[p]));
  end
  ebr_ram ebr_ram_i (.i_clk(clk), .i_rst(rst), .i_true_dual(td), .i_width_a(wa), .i_width_b(wb),
    .i_outreg_a(ora), .i_outreg_b(orb), .i_outclk_sel_a(sla), .i_outclk_sel_b(slb),
    .i_ce_a(ce[0]), .i_we_a(uw[0]), .i_clr_a(uc[0]), .i_addr_a(ua[0]), .i_wdata_a(ud[0]), .i_be_a(ub[0]),
    .o_rdata_a(rd[0]), .i_ce_b(ce[1]), .i_we_b(uw[1]), .i_clr_b(uc[1]), .i_addr_b(ua[1]),
    .i_wdata_b(ud[1]), .i_be_b(ub[1]), .o_rdata_b(rd[1]), .o_cfg_err(cerr));

  // Model: physical bit of data bit k, pairing legality, write, read
  function automatic int pb(ebr_pkg::ebr_width_e w, int a, int k);
    int l = a * tbl[w] + k;
    return (int'(w) > 5) ? l % 4608 : ((l / 8) * 9 + l % 8) % 4608;
  endfunction
  // Cross-group pairing, or a 32/36-bit port in true dual-port mode
  function automatic logic bad(ebr_pkg::ebr_width_e a, ebr_pkg::ebr_width_e b);
    return ((int'(a) > 5) != (int'(b) > 5)) ||
           (td && (a inside {ebr_pkg::EBR_W32, ebr_pkg::EBR_W36} || b inside {ebr_pkg::EBR_W32, ebr_pkg::EBR_W36}));
  endfunction
  function automatic void mwr(int p, int a, logic [35:0] d, logic [3:0] b);
    ebr_pkg::ebr_width_e w = p ? wb : wa;
    if (bad(wa, wb) || (p == 1 && !td))
      return;
    for (int k = 0; k < tbl[w]; k++)
      if (tbl[w] < 16 || b[(int'(w) > 5) ? k / 9 : k / 8])
        mem[pb(w, a, k)] = d[k];
  endfunction
  function automatic logic [35:0] mrd(int p, int a);
    ebr_pkg::ebr_width_e w = p ? wb : wa;
    logic [35:0] x = '0;
    for (int k = 0; k < tbl[w]; k++)
      x[k] = mem[pb(w, a, k)];
    return x;
  endfunction
  function automatic int r(int m);
    return ($random(seed) & 32'h7fffffff) % m;
  endfunction
  function automatic logic [35:0] r36();
    logic [63:0] x;
    x = {$random(seed), $random(seed)};
    return x[35:0];
  endfunction

  // Compare, count and report
  task automatic chk(logic [35:0] got, logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task test_done();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Port drivers, launched just after a rising edge
  task cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task drv(int p, logic q, logic w, int a, logic [35:0] d, logic [3:0] b);
    @(posedge clk);
    rq[p] <= q;
    we[p] <= w;
    ad[p] <= a[11:0];
    wd[p] <= d;
    be[p] <= b;
  endtask
  task idle(int p);
    drv(p, 1'b0, 1'b0, 0, '0, '0);
    cyc(2);
    drv(p, 1'b1, 1'b0, 0, '0, '0);
    drv(p, 1'b0, 1'b0, 0, '0, '0);
  endtask
  task wr(int p, int a, logic [35:0] d, logic [3:0] b);
    drv(p, 1'b1, 1'b1, a, d, b);
    mwr(p, a, d, b);
    idle(p);
  endtask
  task rdw(int p, int a);
    drv(p, 1'b1, 1'b0, a, '0, '0);
    @(posedge clk);
    drv(p, 1'b0, 1'b0, a, '0, '0);
    @(posedge clk);
    #1 chk(rd[p], mrd(p, a));
  endtask
  task cfg(logic t, ebr_pkg::ebr_width_e a, ebr_pkg::ebr_width_e b);
    @(posedge clk);
    td <= t;
    wa <= a;
    wb <= b;
    cyc(2);
  endtask

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #500000;
    n_fail++;
    test_done();
  end

  // Main sequence
  initial begin
    int m, k;
    logic [35:0] v;
    logic        md;
    seed = 32'hb3e8e67c;
    n_fail = 0;
    total_checks = 0;
    {rst, td, ora, orb, sla, slb} = 6'h21;
    wa = ebr_pkg::EBR_W36;
    wb = ebr_pkg::EBR_W36;
    rq = '{2{1'b0}};
    we = '{2{1'b0}};
    cl = '{2{1'b0}};
    ad = '{2{12'h000}};
    wd = '{2{36'h0_0000_0000}};
    be = '{2{4'h0}};
    cyc(2);
    rst <= 1'b0;
    // Whole array filled back to back, registered inputs every cycle
    for (int i = 0; i < 128; i++) begin
      v = r36();
      drv(0, 1'b1, 1'b1, i, v, 4'hf);
      mwr(0, i, v, 4'hf);
    end
    idle(0);
    // Every pairing in both modes
    for (int t = 0; t < 2; t++)
      for (int i = 0; i < 9; i++)
        for (int j = 0; j < 9; j++) begin
          cfg(t[0], ebr_pkg::ebr_width_e'(i), ebr_pkg::ebr_width_e'(j));
          #1 chk(36'(cerr), 36'(bad(wa, wb)));
        end
    // Write under an illegal pairing is dropped
    wr(0, 7, ~mrd(0, 7), 4'hf);
    cfg(1'b0, ebr_pkg::EBR_W36, ebr_pkg::EBR_W36);
    rdw(1, 7);
    // Every lane-enable combination on nine-bit lanes
    for (int i = 0; i < 16; i++) begin
      wr(0, 5, r36(), i[3:0]);
      rdw(1, 5);
    end
    // Port A output register: clear, then advance only on port B enable
    @(posedge clk);
    ora <= 1'b1;
    sla <= 1'b1;
    cl[0] <= 1'b1;
    @(posedge clk);
    cl[0] <= 1'b0;
    #1 chk(rd[0], 36'h0_0000_0000);
    drv(0, 1'b1, 1'b0, 9, '0, '0);
    drv(0, 1'b0, 1'b0, 9, '0, '0);
    cyc(1);
    #1 chk(rd[0], 36'h0_0000_0000);
    drv(1, 1'b1, 1'b0, 0, '0, '0);
    drv(1, 1'b0, 1'b0, 0, '0, '0);
    #1 chk(rd[0], mrd(0, 9));
    // Port B output register cleared while registered
    @(posedge clk);
    orb <= 1'b1;
    cl[1] <= 1'b1;
    @(posedge clk);
    cl[1] <= 1'b0;
    #1 chk(rd[1], 36'h0_0000_0000);
    // Random legal configurations, widths, lanes and addresses
    for (int n = 0; n < 400; n++) begin
      md = 1'($random(seed));
      k = r(2) * 6;
      m = md ? (k ? 2 : 5) : (k ? 3 : 6);
      cfg(md, ebr_pkg::ebr_width_e'(k + r(m)), ebr_pkg::ebr_width_e'(k + r(m)));
      ora <= 1'($random(seed));
      orb <= 1'($random(seed));
      sla <= 1'b0;
      if (r(2) == 1)
        wr(r(2), r(4096), r36(), 4'(r(16)));
      else
        rdw(r(2), r(4096));
    end
    test_done();
  end
endmodule  // ebr_ram_tb_top
